// file: rtl/mpc_gain_channel.sv
// one channel's pending/applied gain with zero-cross apply
`timescale 1ns/1ps
module mpc_gain_channel
  import mpc_pkg::*;
(
  // clock and reset
  input  wire logic              i_mclk,
  input  wire logic              i_clear,
  // register side
  input  wire logic              i_gain_wr,
  input  wire logic [GAIN_W-1:0] i_gain_wdata,
  input  wire logic              i_commit,
  input  wire logic              i_zc_mode,
  // analogue sign-change flag, asynchronous
  input  wire logic              i_zero_cross,
  // results
  output logic [GAIN_W-1:0]      o_pending_gain,
  output logic [GAIN_W-1:0]      o_applied_gain,
  output logic                   o_wait_zc
);
  logic              zc_meta_r;
  logic              zc_sync_r;
  logic [GAIN_W-1:0] pending_r;
  logic [GAIN_W-1:0] pending_nxt;
  logic [GAIN_W-1:0] applied_r;
  logic [GAIN_W-1:0] applied_nxt;
  logic              wait_r;
  logic              wait_nxt;
  wire               apply_now;
  wire               arm_zc;
  wire               zc_hit;

  // two-flop synchroniser for the crossing flag
  always_ff @(posedge i_mclk) begin
    if (i_clear) begin
      zc_meta_r <= 1'b0;
      zc_sync_r <= 1'b0;
    end else begin
      zc_meta_r <= i_zero_cross;
      zc_sync_r <= zc_meta_r;
    end
  end

  // commit either applies now or arms the crossing wait
  assign pending_nxt = i_gain_wr ? i_gain_wdata : pending_r;
  assign apply_now   = i_commit & ~i_zc_mode;
  assign arm_zc      = i_commit & i_zc_mode;
  assign zc_hit      = wait_r & zc_sync_r & ~i_commit;
  assign applied_nxt = (apply_now | zc_hit) ? pending_nxt : applied_r;
  assign wait_nxt    = arm_zc ? 1'b1 : ((apply_now | zc_hit) ? 1'b0 : wait_r);

  // gain state, cleared to reset values while held
  always_ff @(posedge i_mclk) begin
    if (i_clear) begin
      pending_r <= RST_GAIN;
      applied_r <= RST_GAIN;
      wait_r    <= 1'b0;
    end else begin
      pending_r <= pending_nxt;
      applied_r <= applied_nxt;
      wait_r    <= wait_nxt;
    end
  end

  assign o_pending_gain = pending_r;
  assign o_applied_gain = applied_r;
  assign o_wait_zc      = wait_r;
endmodule // mpc_gain_channel

// file: rtl/mpc_mic_preamp_regs.sv
// microphone pre-amplifier control register bank
`timescale 1ns/1ps
module mpc_mic_preamp_regs
  import mpc_pkg::*;
(
  // clock and reset
  input  wire logic              i_mclk,
  input  wire logic              i_sys_rst,
  // master codec enable from the power register logic
  input  wire logic              i_codec_master_on,
  // register port of the control interface
  input  wire logic              i_reg_wr,
  input  wire logic              i_reg_rd,
  input  wire logic [7:0]        i_reg_addr,
  input  wire logic [15:0]       i_reg_wdata,
  output logic [15:0]            o_reg_rdata,
  output logic                   o_reg_rvalid,
  // zero-cross flags from the analogue front end
  input  wire logic              i_left_zero_cross,
  input  wire logic              i_right_zero_cross,
  // input routing switches
  output logic                   o_left_pos_pin_connect,
  output logic                   o_left_neg_pin_connect,
  output logic                   o_left_second_pin_connect,
  output logic                   o_right_pos_pin_connect,
  output logic                   o_right_neg_pin_connect,
  output logic                   o_right_second_pin_connect,
  // pre-amplifier controls
  output logic                   o_left_preamp_on,
  output logic                   o_right_preamp_on,
  output logic                   o_left_preamp_mute,
  output logic                   o_right_preamp_mute,
  output logic [GAIN_W-1:0]      o_left_preamp_gain,
  output logic [GAIN_W-1:0]      o_right_preamp_gain,
  output logic                   o_left_gain_waiting,
  output logic                   o_right_gain_waiting,
  // microphone bias controls
  output logic                   o_mic_bias_on,
  output logic                   o_mic_bias_level_select
);
  // volume register readback layout, shared by both channels
  function automatic logic [15:0] vol_word(input logic on, input logic mute,
                                           input logic zc, input logic [GAIN_W-1:0] gain);
    logic [15:0] w;
    w = 16'h0000;
    w[POS_VOL_PREAMP_ON]  = on;
    w[POS_VOL_MUTE]       = mute;
    w[POS_VOL_ZERO_CROSS] = zc;
    w[POS_VOL_GAIN_LSB +: GAIN_W] = gain;
    return w;
  endfunction

  logic [2:0]        route_left_r;
  logic [2:0]        route_right_r;
  logic              bias_on_r;
  logic              bias_level_r;
  logic              left_on_r;
  logic              right_on_r;
  logic              left_mute_r;
  logic              right_mute_r;
  logic              left_zc_r;
  logic              right_zc_r;
  logic [15:0]       rdata_r;
  logic [15:0]       rdata_nxt;
  logic              rvalid_r;
  logic [GAIN_W-1:0] left_pending;
  logic [GAIN_W-1:0] right_pending;

  wire clear;
  wire wr_pm1;
  wire wr_pm2;
  wire wr_route;
  wire wr_bias;
  wire wr_lvol;
  wire wr_rvol;
  wire commit;

  // master enable holds every register but the read answer at its reset value
  assign clear = i_sys_rst | ~i_codec_master_on;

  // write decode
  assign wr_pm1   = i_reg_wr & (i_reg_addr == ADDR_POWER_MGMT_ONE);
  assign wr_pm2   = i_reg_wr & (i_reg_addr == ADDR_POWER_MGMT_TWO);
  assign wr_route = i_reg_wr & (i_reg_addr == ADDR_MIC_INPUT_ROUTING);
  assign wr_bias  = i_reg_wr & (i_reg_addr == ADDR_MIC_BIAS_CONTROL);
  assign wr_lvol  = i_reg_wr & (i_reg_addr == ADDR_LEFT_INPUT_VOLUME);
  assign wr_rvol  = i_reg_wr & (i_reg_addr == ADDR_RIGHT_INPUT_VOLUME);
  assign commit   = (wr_lvol | wr_rvol) & i_reg_wdata[POS_VOL_COMMIT];

  // input routing register
  always_ff @(posedge i_mclk) begin
    if (clear) begin
      route_left_r  <= RST_ROUTING_LEFT;
      route_right_r <= RST_ROUTING_RIGHT;
    end else if (wr_route) begin
      route_left_r  <= {i_reg_wdata[POS_LEFT_SECOND_PIN], i_reg_wdata[POS_LEFT_NEG_PIN],
                        i_reg_wdata[POS_LEFT_POS_PIN]};
      route_right_r <= {i_reg_wdata[POS_RIGHT_SECOND_PIN], i_reg_wdata[POS_RIGHT_NEG_PIN],
                        i_reg_wdata[POS_RIGHT_POS_PIN]};
    end
  end

  // bias enable, one bit reached from two addresses
  always_ff @(posedge i_mclk) begin
    if (clear) begin
      bias_on_r    <= RST_FLAG;
      bias_level_r <= RST_FLAG;
    end else if (wr_bias) begin
      bias_on_r    <= i_reg_wdata[POS_MIC_BIAS_ON_BC];
      bias_level_r <= i_reg_wdata[POS_MIC_BIAS_LEVEL];
    end else if (wr_pm1) begin
      bias_on_r    <= i_reg_wdata[POS_MIC_BIAS_ON_PM];
    end
  end

  // pre-amplifier enables, shared between power and volume registers
  always_ff @(posedge i_mclk) begin
    if (clear) begin
      left_on_r  <= RST_FLAG;
      right_on_r <= RST_FLAG;
    end else begin
      if (wr_lvol) begin
        left_on_r <= i_reg_wdata[POS_VOL_PREAMP_ON];
      end else if (wr_pm2) begin
        left_on_r <= i_reg_wdata[POS_LEFT_PREAMP_ON_PM];
      end
      if (wr_rvol) begin
        right_on_r <= i_reg_wdata[POS_VOL_PREAMP_ON];
      end else if (wr_pm2) begin
        right_on_r <= i_reg_wdata[POS_RIGHT_PREAMP_ON_PM];
      end
    end
  end

  // mute and zero-cross mode bits of the volume registers
  always_ff @(posedge i_mclk) begin
    if (clear) begin
      left_mute_r  <= RST_FLAG;
      right_mute_r <= RST_FLAG;
      left_zc_r    <= RST_FLAG;
      right_zc_r   <= RST_FLAG;
    end else begin
      if (wr_lvol) begin
        left_mute_r <= i_reg_wdata[POS_VOL_MUTE];
        left_zc_r   <= i_reg_wdata[POS_VOL_ZERO_CROSS];
      end
      if (wr_rvol) begin
        right_mute_r <= i_reg_wdata[POS_VOL_MUTE];
        right_zc_r   <= i_reg_wdata[POS_VOL_ZERO_CROSS];
      end
    end
  end

  // left gain path, mode bit taken as written with the commit
  mpc_gain_channel u_left (
    .i_mclk         (i_mclk),
    .i_clear        (clear),
    .i_gain_wr      (wr_lvol),
    .i_gain_wdata   (i_reg_wdata[POS_VOL_GAIN_LSB +: GAIN_W]),
    .i_commit       (commit),
    .i_zc_mode      (wr_lvol ? i_reg_wdata[POS_VOL_ZERO_CROSS] : left_zc_r),
    .i_zero_cross   (i_left_zero_cross),
    .o_pending_gain (left_pending),
    .o_applied_gain (o_left_preamp_gain),
    .o_wait_zc      (o_left_gain_waiting)
  );

  // right gain path, same layout as the left
  mpc_gain_channel u_right (
    .i_mclk         (i_mclk),
    .i_clear        (clear),
    .i_gain_wr      (wr_rvol),
    .i_gain_wdata   (i_reg_wdata[POS_VOL_GAIN_LSB +: GAIN_W]),
    .i_commit       (commit),
    .i_zc_mode      (wr_rvol ? i_reg_wdata[POS_VOL_ZERO_CROSS] : right_zc_r),
    .i_zero_cross   (i_right_zero_cross),
    .o_pending_gain (right_pending),
    .o_applied_gain (o_right_preamp_gain),
    .o_wait_zc      (o_right_gain_waiting)
  );

  // read decode, unmapped addresses read zero
  always_comb begin
    rdata_nxt = 16'h0000;
    if (i_reg_addr == ADDR_POWER_MGMT_ONE) begin
      rdata_nxt[POS_MIC_BIAS_ON_PM] = bias_on_r;
    end else if (i_reg_addr == ADDR_POWER_MGMT_TWO) begin
      rdata_nxt[POS_LEFT_PREAMP_ON_PM]  = left_on_r;
      rdata_nxt[POS_RIGHT_PREAMP_ON_PM] = right_on_r;
    end else if (i_reg_addr == ADDR_MIC_INPUT_ROUTING) begin
      rdata_nxt[POS_LEFT_POS_PIN]     = route_left_r[0];
      rdata_nxt[POS_LEFT_NEG_PIN]     = route_left_r[1];
      rdata_nxt[POS_LEFT_SECOND_PIN]  = route_left_r[2];
      rdata_nxt[POS_RIGHT_POS_PIN]    = route_right_r[0];
      rdata_nxt[POS_RIGHT_NEG_PIN]    = route_right_r[1];
      rdata_nxt[POS_RIGHT_SECOND_PIN] = route_right_r[2];
    end else if (i_reg_addr == ADDR_MIC_BIAS_CONTROL) begin
      rdata_nxt[POS_MIC_BIAS_ON_BC] = bias_on_r;
      rdata_nxt[POS_MIC_BIAS_LEVEL] = bias_level_r;
    end else if (i_reg_addr == ADDR_LEFT_INPUT_VOLUME) begin
      rdata_nxt = vol_word(left_on_r, left_mute_r, left_zc_r, left_pending);
    end else if (i_reg_addr == ADDR_RIGHT_INPUT_VOLUME) begin
      rdata_nxt = vol_word(right_on_r, right_mute_r, right_zc_r, right_pending);
    end
  end

  // registered read answer, one cycle after the strobe
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      rdata_r  <= 16'h0000;
      rvalid_r <= 1'b0;
    end else begin
      rvalid_r <= i_reg_rd;
      if (i_reg_rd) begin
        rdata_r <= rdata_nxt;
      end
    end
  end

  // outputs
  assign o_reg_rdata                = rdata_r;
  assign o_reg_rvalid               = rvalid_r;
  assign o_left_pos_pin_connect     = route_left_r[0];
  assign o_left_neg_pin_connect     = route_left_r[1];
  assign o_left_second_pin_connect  = route_left_r[2];
  assign o_right_pos_pin_connect    = route_right_r[0];
  assign o_right_neg_pin_connect    = route_right_r[1];
  assign o_right_second_pin_connect = route_right_r[2];
  assign o_left_preamp_on           = left_on_r;
  assign o_right_preamp_on          = right_on_r;
  assign o_left_preamp_mute         = left_mute_r;
  assign o_right_preamp_mute        = right_mute_r;
  assign o_mic_bias_on              = bias_on_r;
  assign o_mic_bias_level_select    = bias_level_r;
endmodule // mpc_mic_preamp_regs

// file: rtl/mpc_pkg.sv
// constants for the microphone pre-amplifier control registers
package mpc_pkg;
  // register addresses (index on the control interface)
  localparam logic [7:0] ADDR_POWER_MGMT_ONE      = 8'h08;
  localparam logic [7:0] ADDR_POWER_MGMT_TWO      = 8'h09;
  localparam logic [7:0] ADDR_MIC_INPUT_ROUTING   = 8'h48;
  localparam logic [7:0] ADDR_MIC_BIAS_CONTROL    = 8'h4a;
  localparam logic [7:0] ADDR_LEFT_INPUT_VOLUME   = 8'h50;
  localparam logic [7:0] ADDR_RIGHT_INPUT_VOLUME  = 8'h51;

  // field positions
  localparam int POS_MIC_BIAS_ON_PM    = 4;
  localparam int POS_LEFT_PREAMP_ON_PM = 8;
  localparam int POS_RIGHT_PREAMP_ON_PM = 9;
  localparam int POS_LEFT_POS_PIN      = 0;
  localparam int POS_LEFT_NEG_PIN      = 1;
  localparam int POS_LEFT_SECOND_PIN   = 2;
  localparam int POS_RIGHT_POS_PIN     = 8;
  localparam int POS_RIGHT_NEG_PIN     = 9;
  localparam int POS_RIGHT_SECOND_PIN  = 10;
  localparam int POS_MIC_BIAS_ON_BC    = 15;
  localparam int POS_MIC_BIAS_LEVEL    = 14;
  localparam int POS_VOL_PREAMP_ON     = 15;
  localparam int POS_VOL_MUTE          = 14;
  localparam int POS_VOL_ZERO_CROSS    = 13;
  localparam int POS_VOL_COMMIT        = 8;
  localparam int POS_VOL_GAIN_LSB      = 2;
  localparam int GAIN_W                = 6;

  // reset values
  localparam logic [2:0]        RST_ROUTING_LEFT  = 3'h3;
  localparam logic [2:0]        RST_ROUTING_RIGHT = 3'h3;
  localparam logic [GAIN_W-1:0] RST_GAIN          = 6'h10;
  localparam logic              RST_FLAG          = 1'b0;
endpackage

// file: verification/mpc_mic_preamp_regs_bench.sv
// self-checking bench for the microphone pre-amplifier control register bank
`timescale 1ns/1ps
module mpc_mic_preamp_regs_bench;
  import mpc_pkg::*;
  logic i_mclk = 1'b0, i_sys_rst = 1'b1, i_codec_master_on = 1'b1, i_reg_wr = 1'b0, i_reg_rd = 1'b0;
  logic i_left_zero_cross = 1'b0, i_right_zero_cross = 1'b0;
  logic [7:0] i_reg_addr = 8'h00;
  logic [15:0] i_reg_wdata = 16'h0000;
  logic [15:0] o_reg_rdata;
  logic o_reg_rvalid, lpos, lneg, lsec, rpos, rneg, rsec, l_on, r_on, l_mute, r_mute, l_wait, r_wait, b_on, b_lvl;
  logic [GAIN_W-1:0] l_gain, r_gain;
  int fail_count = 0;
  int checks_done = 0;
  // packed views of the controls for compact compares
  wire [15:0] ctl = {l_wait, r_wait, l_on, r_on, l_mute, r_mute, b_on, b_lvl, 2'b00, lpos, lneg, lsec, rpos, rneg, rsec};
  wire [15:0] gains = {4'h0, l_gain, r_gain};
  wire [7:0] ra [7] = '{ADDR_POWER_MGMT_ONE, ADDR_POWER_MGMT_TWO, ADDR_MIC_INPUT_ROUTING, ADDR_MIC_BIAS_CONTROL,
                        ADDR_LEFT_INPUT_VOLUME, ADDR_RIGHT_INPUT_VOLUME, 8'h20};
  wire [15:0] rv [7] = '{16'h0000, 16'h0000, 16'h0303, 16'h0000, 16'h0040, 16'h0040, 16'h0000};

  mpc_mic_preamp_regs dut (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_codec_master_on(i_codec_master_on),
    .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
    .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid), .i_left_zero_cross(i_left_zero_cross),
    .i_right_zero_cross(i_right_zero_cross), .o_left_pos_pin_connect(lpos), .o_left_neg_pin_connect(lneg),
    .o_left_second_pin_connect(lsec), .o_right_pos_pin_connect(rpos), .o_right_neg_pin_connect(rneg),
    .o_right_second_pin_connect(rsec), .o_left_preamp_on(l_on), .o_right_preamp_on(r_on),
    .o_left_preamp_mute(l_mute), .o_right_preamp_mute(r_mute), .o_left_preamp_gain(l_gain),
    .o_right_preamp_gain(r_gain), .o_left_gain_waiting(l_wait), .o_right_gain_waiting(r_wait),
    .o_mic_bias_on(b_on), .o_mic_bias_level_select(b_lvl));

  // clock generator, 100 ns period
  initial forever #50 i_mclk = ~i_mclk;

  // compare one value and count
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // one register write, returns once its effect has landed
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge i_mclk);
    i_reg_wr <= 1'b1;
    i_reg_addr <= a;
    i_reg_wdata <= d;
    @(posedge i_mclk);
    i_reg_wr <= 1'b0;
    #1;
  endtask

  // one register read with expected data
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    @(posedge i_mclk);
    i_reg_rd <= 1'b1;
    i_reg_addr <= a;
    @(posedge i_mclk);
    i_reg_rd <= 1'b0;
    #1;
    chk("rvalid", {15'h0000, o_reg_rvalid}, 16'h0001);
    chk("rdata", o_reg_rdata, exp);
  endtask

  // verdict and end of run
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // hang guard, far beyond the 84 or so cycles the tests need
  initial begin
    repeat (3000) @(posedge i_mclk);
    fail_count++;
    close_out;
  end

  // test sequence
  initial begin
    repeat (16) @(posedge i_mclk);
    i_sys_rst <= 1'b0;
    #1;
    chk("ctl", ctl, 16'h0036);
    chk("gains", gains, 16'h0410);
    for (int k = 0; k < 7; k++) rd(ra[k], rv[k]);
    // routing with reserved bits set
    wr(ADDR_MIC_INPUT_ROUTING, 16'hfffe);
    chk("ctl", ctl, 16'h001f);
    rd(ADDR_MIC_INPUT_ROUTING, 16'h0706);
    // bias enable through both places
    wr(ADDR_POWER_MGMT_ONE, 16'h0010);
    chk("ctl", ctl, 16'h021f);
    rd(ADDR_MIC_BIAS_CONTROL, 16'h8000);
    wr(ADDR_MIC_BIAS_CONTROL, 16'h4000);
    chk("ctl", ctl, 16'h011f);
    rd(ADDR_POWER_MGMT_ONE, 16'h0000);
    wr(ADDR_POWER_MGMT_TWO, 16'h0100);
    rd(ADDR_LEFT_INPUT_VOLUME, 16'h8040);
    // gains pending, then shared commit
    wr(ADDR_LEFT_INPUT_VOLUME, 16'h80fc);
    wr(ADDR_RIGHT_INPUT_VOLUME, 16'h0014);
    chk("gains", gains, 16'h0410);
    rd(ADDR_LEFT_INPUT_VOLUME, 16'h80fc);
    wr(ADDR_RIGHT_INPUT_VOLUME, 16'h0114);
    chk("gains", gains, 16'h0fc5);
    rd(ADDR_RIGHT_INPUT_VOLUME, 16'h0014);
    // zero-cross commit waits for the sign-change flag
    wr(ADDR_LEFT_INPUT_VOLUME, 16'ha180);
    chk("ctl", ctl, 16'ha11f);
    chk("gains", gains, 16'h0fc5);
    @(posedge i_mclk);
    i_left_zero_cross <= 1'b1;
    repeat (4) @(posedge i_mclk);
    i_left_zero_cross <= 1'b0;
    #1;
    chk("gains", gains, 16'h0805);
    chk("ctl", ctl, 16'h211f);
    // mute without commit
    wr(ADDR_RIGHT_INPUT_VOLUME, 16'h4000);
    chk("ctl", ctl, 16'h251f);
    chk("gains", gains, 16'h0805);
    // right enable through the power register, left mute with commit
    wr(ADDR_POWER_MGMT_TWO, 16'h0200);
    chk("ctl", ctl, 16'h151f);
    rd(ADDR_RIGHT_INPUT_VOLUME, 16'hc000);
    wr(ADDR_LEFT_INPUT_VOLUME, 16'h4110);
    chk("ctl", ctl, 16'h1d1f);
    chk("gains", gains, 16'h0100);
    // right zero-cross commit waits for its own flag
    wr(ADDR_RIGHT_INPUT_VOLUME, 16'ha1fc);
    chk("ctl", ctl, 16'h591f);
    chk("gains", gains, 16'h0100);
    @(posedge i_mclk);
    i_right_zero_cross <= 1'b1;
    repeat (4) @(posedge i_mclk);
    i_right_zero_cross <= 1'b0;
    #1;
    chk("gains", gains, 16'h013f);
    chk("ctl", ctl, 16'h191f);
    // master enable off holds every control and gain at reset
    @(posedge i_mclk);
    i_codec_master_on <= 1'b0;
    wr(ADDR_MIC_INPUT_ROUTING, 16'h0000);
    chk("ctl", ctl, 16'h0036);
    chk("gains", gains, 16'h0410);
    @(posedge i_mclk);
    i_codec_master_on <= 1'b1;
    rd(ADDR_MIC_INPUT_ROUTING, 16'h0303);
    close_out;
  end
endmodule // mpc_mic_preamp_regs_bench

// file: verification/mpc_mic_preamp_regs_properties.sv
// checker for the microphone pre-amplifier control register bank
`timescale 1ns/1ps
module mpc_regs_props
  import mpc_pkg::*;
(
  // clock, reset and master enable
  input wire logic              i_mclk, i_sys_rst, i_codec_master_on,
  // register port
  input wire logic              i_reg_wr,
  input wire logic [7:0]        i_reg_addr,
  input wire logic [15:0]       i_reg_wdata,
  input wire logic              i_left_zero_cross,
  // controls under watch
  input wire logic              o_left_pos_pin_connect, o_left_neg_pin_connect, o_left_second_pin_connect,
  input wire logic              o_right_pos_pin_connect, o_right_neg_pin_connect, o_right_second_pin_connect,
  input wire logic              o_left_preamp_on, o_right_preamp_on, o_left_preamp_mute,
  input wire logic [GAIN_W-1:0] o_left_preamp_gain, o_right_preamp_gain,
  input wire logic              o_left_gain_waiting, o_right_gain_waiting,
  input wire logic              o_mic_bias_on, o_mic_bias_level_select
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_sys_rst);

  // accepted write and the data it carried one edge ago
  wire         wr_ok = i_reg_wr & i_codec_master_on;
  logic [15:0] wd_r;
  always_ff @(posedge i_mclk) wd_r <= i_reg_wdata;

  // register writes landing on the controls
  chk_left_routing: assert property (wr_ok && i_reg_addr == ADDR_MIC_INPUT_ROUTING |=>
    {o_left_pos_pin_connect, o_left_neg_pin_connect, o_left_second_pin_connect} == {wd_r[0], wd_r[1], wd_r[2]})
    else $error("left routing does not follow write");
  chk_right_routing: assert property (wr_ok && i_reg_addr == ADDR_MIC_INPUT_ROUTING |=>
    {o_right_pos_pin_connect, o_right_neg_pin_connect, o_right_second_pin_connect} == {wd_r[8], wd_r[9], wd_r[10]})
    else $error("right routing does not follow write");
  chk_left_mute: assert property (wr_ok && i_reg_addr == ADDR_LEFT_INPUT_VOLUME |=>
    o_left_preamp_mute == wd_r[14]) else $error("left mute does not follow write");
  chk_zc_arm: assert property (wr_ok && i_reg_addr == ADDR_LEFT_INPUT_VOLUME && i_reg_wdata[8]
    && i_reg_wdata[13] |=> o_left_gain_waiting && $stable(o_left_preamp_gain)) else $error("zero-cross commit not held");
  chk_gain_pending: assert property (wr_ok && !i_reg_wdata[8] && !o_left_gain_waiting && !o_right_gain_waiting
    && (i_reg_addr == ADDR_LEFT_INPUT_VOLUME || i_reg_addr == ADDR_RIGHT_INPUT_VOLUME)
    |=> $stable(o_left_preamp_gain) && $stable(o_right_preamp_gain)) else $error("gain moved without commit");
  chk_left_commit: assert property (wr_ok && i_reg_addr == ADDR_LEFT_INPUT_VOLUME && i_reg_wdata[8]
    && !i_reg_wdata[13] |=> o_left_preamp_gain == wd_r[7:2]) else $error("left gain not applied at commit");
  chk_right_commit: assert property (wr_ok && i_reg_addr == ADDR_RIGHT_INPUT_VOLUME && i_reg_wdata[8]
    && !i_reg_wdata[13] |=> o_right_preamp_gain == wd_r[7:2]) else $error("right gain not applied at commit");
  chk_bias_power: assert property (wr_ok && i_reg_addr == ADDR_POWER_MGMT_ONE |=>
    o_mic_bias_on == wd_r[4]) else $error("bias enable not set from power register");
  chk_bias_alias: assert property (wr_ok && i_reg_addr == ADDR_MIC_BIAS_CONTROL |=>
    o_mic_bias_on == wd_r[15] && o_mic_bias_level_select == wd_r[14]) else $error("bias control write lost");
  chk_preamp_alias: assert property (wr_ok && i_reg_addr == ADDR_POWER_MGMT_TWO |=>
    o_left_preamp_on == wd_r[8] && o_right_preamp_on == wd_r[9]) else $error("preamp enables not set");
  chk_master_hold: assert property (!i_codec_master_on |=> o_left_preamp_gain == RST_GAIN
    && o_right_preamp_gain == RST_GAIN && !o_mic_bias_on && !o_left_preamp_on && o_left_pos_pin_connect
    && !o_left_second_pin_connect && !o_left_gain_waiting) else $error("registers not held while master off");
  chk_zc_apply: assert property (o_left_gain_waiting && i_left_zero_cross && !i_reg_wr |->
    ##[1:4] !o_left_gain_waiting) else $error("zero-cross gain not applied in time");

  // main scenarios reached
  cov_zc_done: cover property (o_left_gain_waiting ##[1:4] !o_left_gain_waiting);
  cov_master_off: cover property (!i_codec_master_on);
  cov_bias_write: cover property (wr_ok && i_reg_addr == ADDR_MIC_BIAS_CONTROL);
  cov_right_zc: cover property (o_right_gain_waiting ##[1:8] !o_right_gain_waiting);
endmodule // mpc_regs_props

bind mpc_mic_preamp_regs mpc_regs_props u_props (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst),
  .i_codec_master_on(i_codec_master_on), .i_reg_wr(i_reg_wr), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
  .i_left_zero_cross(i_left_zero_cross), .o_left_pos_pin_connect(o_left_pos_pin_connect),
  .o_left_neg_pin_connect(o_left_neg_pin_connect), .o_left_second_pin_connect(o_left_second_pin_connect),
  .o_right_pos_pin_connect(o_right_pos_pin_connect), .o_right_neg_pin_connect(o_right_neg_pin_connect),
  .o_right_second_pin_connect(o_right_second_pin_connect), .o_left_preamp_on(o_left_preamp_on),
  .o_right_preamp_on(o_right_preamp_on), .o_left_preamp_mute(o_left_preamp_mute),
  .o_left_preamp_gain(o_left_preamp_gain), .o_right_preamp_gain(o_right_preamp_gain),
  .o_left_gain_waiting(o_left_gain_waiting), .o_right_gain_waiting(o_right_gain_waiting),
  .o_mic_bias_on(o_mic_bias_on), .o_mic_bias_level_select(o_mic_bias_level_select));
